// ==== async_serial_adapter.sv ====
`timescale 1ns/1ps
`include "async_serial_adapter_defs.svh"
module async_serial_adapter
  import async_serial_adapter_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_select_high_a,
  input  wire logic       i_select_high_b,
  input  wire logic       i_select_low_n,
  input  wire logic       i_register_pick,
  input  wire logic       i_read_write,
  input  wire logic       i_bus_strobe,
  input  wire logic [7:0] i_bus_lines,
  output logic      [7:0] o_bus_lines,
  output logic            o_bus_lines_oe,
  output logic            o_irq_n,
  output logic            o_irq_oe,
  input  wire logic       i_tx_bit_clock,
  input  wire logic       i_rx_bit_clock,
  input  wire logic       i_rx_data,
  output logic            o_tx_data,
  input  wire logic       i_cts_n,
  input  wire logic       i_dcd_n,
  output logic            o_rts_n
);
  // two-stage synchronisers for all pins
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] pin_in;
  assign pin_in = {i_select_high_a, i_select_high_b, i_select_low_n, i_bus_strobe,
                   i_tx_bit_clock, i_rx_bit_clock, i_cts_n, i_dcd_n};
  logic [1:0] rxd_sync_q;
  logic [9:0] pick_sync_q;
  logic [9:0] pick_s2_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q        <= 8'hff;
      s2_q        <= 8'hff;
      s3_q        <= 8'hff;
      rxd_sync_q  <= 2'h3;
      pick_sync_q <= 10'h000;
      pick_s2_q   <= 10'h000;
    end else begin
      s1_q        <= pin_in;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      rxd_sync_q  <= {rxd_sync_q[0], i_rx_data};
      pick_sync_q <= {i_register_pick, i_read_write, i_bus_lines};
      pick_s2_q   <= pick_sync_q;
    end
  end

  logic sel, strobe, strobe_fall, tx_fall, rx_rise, cts_n, dcd_n, rxd;
  assign sel         = s2_q[7] & s2_q[6] & ~s2_q[5];
  assign strobe      = s2_q[4];
  assign strobe_fall = s3_q[4] & ~s2_q[4];
  assign tx_fall     = s3_q[3] & ~s2_q[3];
  assign rx_rise     = ~s3_q[2] & s2_q[2];
  assign cts_n       = s2_q[1];
  assign dcd_n       = s2_q[0];
  assign rxd         = rxd_sync_q[1];

  bus_req_t req;
  assign req = '{sel: sel, pick: pick_s2_q[9], read: pick_s2_q[8],
                 wdata: pick_s2_q[7:0]};

  // register and status state
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] thr_q, thr_d;
  logic       thr_full_q, thr_full_d;
  logic [7:0] rhr_q, rhr_d;
  logic       rx_full_q, rx_full_d;
  logic       fe_q, fe_d, pe_q, pe_d, ov_q, ov_d, ov_pend_q, ov_pend_d;
  logic       dcd_flag_q, dcd_flag_d, dcd_prev_q, st_read_q, st_read_d;
  logic [7:0] rdata_q, rdata_d;
  logic       oe_q, oe_d, irq_q, irq_d, rts_q, rts_d;

  // transmit and receive engine state
  tx_state_t  txs_q, txs_d;
  rx_state_t  rxs_q, rxs_d;
  logic [7:0] tsh_q, tsh_d, rsh_q, rsh_d;
  logic [3:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic       tpar_q, tpar_d, rpar_q, rpar_d, txd_q, txd_d;
  logic       rx_restart, rx_half, rx_tick, tx_tick, tx_restart;

  divide_t div;
  frame_t  fr;
  logic    mreset;
  assign div    = divide_t'(cfg_q[`CFG_DIV_HI:`CFG_DIV_LO]);
  assign mreset = (div == div_reset);

  // word field decode, used by both engines
  function automatic frame_t decode_frame(input logic [2:0] w);
    frame_t f;
    f.eight    = w[2];
    f.par_en   = ~w[2] | w[1];
    f.par_odd  = w[0];
    f.two_stop = ~w[1] & ~(w[2] & w[0]);
    return f;
  endfunction
  assign fr = decode_frame(cfg_q[`CFG_WORD_HI:`CFG_WORD_LO]);

  logic [3:0] nbits;
  assign nbits = fr.eight ? 4'h8 : 4'h7;

  async_serial_bit_timer u_tx_timer (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_edge    (tx_fall),
    .i_restart (tx_restart),
    .i_half    (1'b0),
    .i_div     (div),
    .o_tick    (tx_tick)
  );

  async_serial_bit_timer u_rx_timer (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_edge    (rx_rise),
    .i_restart (rx_restart),
    .i_half    (rx_half),
    .i_div     (div),
    .o_tick    (rx_tick)
  );

  logic wr_strobe, rd_strobe;
  assign wr_strobe = req.sel & strobe_fall & ~req.read;
  assign rd_strobe = req.sel & strobe_fall & req.read;

  // transmitter: holding register feeds shift register
  always_comb begin
    txs_d      = txs_q;
    tsh_d      = tsh_q;
    tcnt_d     = tcnt_q;
    tpar_d     = tpar_q;
    txd_d      = txd_q;
    thr_d      = thr_q;
    thr_full_d = thr_full_q;
    tx_restart = 1'b0;
    if (wr_strobe && req.pick) begin
      thr_d      = req.wdata;
      thr_full_d = 1'b1;
    end
    case (txs_q)
      tx_idle: begin
        txd_d = ~(cfg_q[`CFG_TXC_HI] & cfg_q[`CFG_TXC_LO]);
        if (thr_full_q && tx_tick) begin
          tsh_d      = thr_q;
          thr_full_d = wr_strobe && req.pick;
          tpar_d     = fr.par_odd;
          txd_d      = 1'b0;
          txs_d      = tx_start;
        end else begin
          tx_restart = ~thr_full_q & tx_fall & (div == div_1);
        end
      end
      tx_start, tx_data: begin
        if (tx_tick) begin
          if (txs_q == tx_start) begin
            tcnt_d = 4'h0;
            txs_d  = tx_data;
          end
          if (txs_q == tx_start || tcnt_q < nbits) begin
            txd_d  = tsh_q[0];
            tpar_d = tpar_q ^ tsh_q[0];
            tsh_d  = {1'b0, tsh_q[7:1]};
            tcnt_d = (txs_q == tx_start) ? 4'h1 : tcnt_q + 4'h1;
          end else if (fr.par_en && tcnt_q == nbits) begin
            txd_d  = tpar_q;
            tcnt_d = tcnt_q + 4'h1;
          end else begin
            txd_d  = 1'b1;
            tcnt_d = fr.two_stop ? 4'h1 : 4'h0;
            txs_d  = tx_stop;
          end
        end
      end
      tx_stop: begin
        if (tx_tick) begin
          if (tcnt_q != 4'h0) begin
            tcnt_d = 4'h0;
          end else begin
            txs_d = tx_idle;
          end
        end
      end
      default: txs_d = tx_idle;
    endcase
    if (mreset) begin
      txs_d      = tx_idle;
      txd_d      = 1'b1;
      thr_full_d = 1'b0;
    end
  end

  // receiver: start check, data, parity, stop
  logic rx_load;
  logic rx_load_fe, rx_load_pe;
  always_comb begin
    rxs_d      = rxs_q;
    rsh_d      = rsh_q;
    rcnt_d     = rcnt_q;
    rpar_d     = rpar_q;
    rx_restart = 1'b0;
    rx_half    = (rxs_q == rx_idle) || (rxs_q == rx_start);
    rx_load    = 1'b0;
    rx_load_fe = 1'b0;
    rx_load_pe = 1'b0;
    case (rxs_q)
      rx_idle: begin
        rx_restart = 1'b1;
        if (rx_rise && !rxd) begin
          rxs_d      = (div == div_1) ? rx_data : rx_start;
          rsh_d      = 8'h00;
          rcnt_d     = 4'h0;
          rpar_d     = fr.par_odd;
          rx_restart = (div != div_1);
        end
      end
      rx_start: begin
        if (rx_tick) begin
          rxs_d = rxd ? rx_idle : rx_data;
        end
      end
      rx_data: begin
        if (rx_tick) begin
          if (rcnt_q < nbits) begin
            rsh_d  = fr.eight ? {rxd, rsh_q[7:1]} : {1'b0, rxd, rsh_q[6:1]};
            rpar_d = rpar_q ^ rxd;
            rcnt_d = rcnt_q + 4'h1;
          end else begin
            rpar_d = rpar_q ^ rxd;
            rcnt_d = rcnt_q + 4'h1;
            rxs_d  = rx_stop;
          end
          if (rcnt_q == nbits - 4'h1 && !fr.par_en) begin
            rxs_d = rx_stop;
          end
        end
      end
      rx_stop: begin
        if (rx_tick) begin
          rx_load    = 1'b1;
          rx_load_fe = ~rxd;
          rx_load_pe = fr.par_en & rpar_q;
          rxs_d      = rx_idle;
        end
      end
      default: rxs_d = rx_idle;
    endcase
    if (mreset || dcd_n) begin
      rxs_d = rx_idle;
    end
  end

  // status, bus read data and outputs
  logic cts_gate, irq_cause;
  always_comb begin
    cfg_d      = cfg_q;
    rhr_d      = rhr_q;
    rx_full_d  = rx_full_q;
    fe_d       = fe_q;
    pe_d       = pe_q;
    ov_d       = ov_q;
    ov_pend_d  = ov_pend_q;
    dcd_flag_d = dcd_flag_q;
    st_read_d  = st_read_q;
    if (wr_strobe && !req.pick) begin
      cfg_d = req.wdata;
    end
    if (rd_strobe && !req.pick) begin
      st_read_d = dcd_flag_q;
    end
    if (rd_strobe && req.pick) begin
      rx_full_d = ov_pend_q;
      ov_d      = ov_pend_q;
      ov_pend_d = 1'b0;
      if (st_read_q) begin
        dcd_flag_d = 1'b0;
        st_read_d  = 1'b0;
      end
    end
    if (rx_load) begin
      if (rx_full_q && !(rd_strobe && req.pick)) begin
        ov_pend_d = 1'b1;
      end else begin
        rhr_d     = rsh_q;
        rx_full_d = 1'b1;
        fe_d      = rx_load_fe;
        pe_d      = rx_load_pe;
      end
    end
    if (dcd_n && !dcd_prev_q) begin
      dcd_flag_d = 1'b1;
    end
    if (mreset) begin
      rx_full_d  = 1'b0;
      fe_d       = 1'b0;
      pe_d       = 1'b0;
      ov_d       = 1'b0;
      ov_pend_d  = 1'b0;
      dcd_flag_d = 1'b0;
      st_read_d  = 1'b0;
    end
    cts_gate  = ~thr_full_q & ~cts_n;
    irq_cause = (cfg_q[`CFG_RIE] & (rx_full_q | dcd_flag_q | ov_q))
              | (cfg_q[`CFG_TXC_HI:`CFG_TXC_LO] == 2'h1 & cts_gate);
    rdata_d   = req.pick ? rhr_q
              : {irq_cause, pe_q, ov_q, fe_q, cts_n, dcd_flag_q | dcd_n,
                 cts_gate, rx_full_q & ~dcd_n};
    oe_d      = req.sel & req.read & strobe;
    irq_d     = ~irq_cause;
    rts_d     = (cfg_q[`CFG_TXC_HI:`CFG_TXC_LO] == 2'h2);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q      <= `CFG_RESET;
      thr_q      <= 8'h00;
      thr_full_q <= 1'b0;
      rhr_q      <= 8'h00;
      rx_full_q  <= 1'b0;
      fe_q       <= 1'b0;
      pe_q       <= 1'b0;
      ov_q       <= 1'b0;
      ov_pend_q  <= 1'b0;
      dcd_flag_q <= 1'b0;
      dcd_prev_q <= `SYNC_RESET;
      st_read_q  <= 1'b0;
      rdata_q    <= 8'h00;
      oe_q       <= 1'b0;
      irq_q      <= 1'b1;
      rts_q      <= 1'b1;
      txs_q      <= tx_idle;
      rxs_q      <= rx_idle;
      tsh_q      <= 8'h00;
      rsh_q      <= 8'h00;
      tcnt_q     <= 4'h0;
      rcnt_q     <= 4'h0;
      tpar_q     <= 1'b0;
      rpar_q     <= 1'b0;
      txd_q      <= 1'b1;
    end else begin
      cfg_q      <= cfg_d;
      thr_q      <= thr_d;
      thr_full_q <= thr_full_d;
      rhr_q      <= rhr_d;
      rx_full_q  <= rx_full_d;
      fe_q       <= fe_d;
      pe_q       <= pe_d;
      ov_q       <= ov_d;
      ov_pend_q  <= ov_pend_d;
      dcd_flag_q <= dcd_flag_d;
      dcd_prev_q <= dcd_n;
      st_read_q  <= st_read_d;
      rdata_q    <= rdata_d;
      oe_q       <= oe_d;
      irq_q      <= irq_d;
      rts_q      <= rts_d;
      txs_q      <= txs_d;
      rxs_q      <= rxs_d;
      tsh_q      <= tsh_d;
      rsh_q      <= rsh_d;
      tcnt_q     <= tcnt_d;
      rcnt_q     <= rcnt_d;
      tpar_q     <= tpar_d;
      rpar_q     <= rpar_d;
      txd_q      <= txd_d;
    end
  end

  // pins straight from flip-flops, except o_irq_n tied low and o_irq_oe inverted from irq_q; irq pin open drain
  assign o_bus_lines    = rdata_q;
  assign o_bus_lines_oe = oe_q;
  assign o_irq_n        = 1'b0;
  assign o_irq_oe       = ~irq_q;
  assign o_tx_data      = txd_q;
  assign o_rts_n        = rts_q;
endmodule

// ==== async_serial_adapter_bench.sv ====
`timescale 1ns/1ps
module async_serial_adapter_bench;
  import async_serial_adapter_pkg::*;
  logic        i_clk, i_rst_b, i_select_high_a, i_select_high_b, i_select_low_n;
  logic        i_register_pick, i_read_write, i_bus_strobe, i_rx_data, i_cts_n;
  logic        i_dcd_n, i_tx_bit_clock, i_rx_bit_clock, o_irq_n, o_irq_oe;
  logic        o_tx_data, o_rts_n, o_bus_lines_oe, send, busy, got, oe_q;
  logic [7:0]  i_bus_lines, o_bus_lines, d;
  logic [10:0] bits, frame;
  logic [3:0]  n;
  logic [6:0]  mul = 7'd1;
  logic [15:0] e;
  logic [15:0] rq[$];
  logic [10:0] tq[$];
  logic [31:0] seed = 32'h334e;
  logic [7:0]  rcfg[3] = '{8'h14, 8'h18, 8'h14};
  logic [7:0]  rexp[3] = '{8'h03, 8'h43, 8'h13};
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_got = 0;
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  assign i_rx_bit_clock = i_tx_bit_clock;
  async_serial_adapter dut (.*);
  async_serial_peer peer (.i_send(send), .i_bits(bits), .i_n(n), .i_mul(mul),
    .i_line(o_tx_data),
    .o_bit_clock(i_tx_bit_clock), .o_rx_line(i_rx_data), .o_busy(busy),
    .o_got(got), .o_frame(frame));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected wire frame after the start bit, with its bit count on top
  function automatic logic [14:0] frame_of(input logic [2:0] w, input logic [7:0] v);
    logic [10:0] f;
    logic [3:0]  c;
    c = w[2] ? 4'd8 : 4'd7;
    f = w[2] ? {3'h7, v} : {4'hf, v[6:0]};
    if (w != 3'd4 && w != 3'd5) begin
      f[c] = (w[2] ? ^v : ^v[6:0]) ^ w[0];
      c++;
    end
    c = c + ((w < 3'd2 || w == 3'd4) ? 4'd2 : 4'd1);
    return {c, f & ((11'h1 << c) - 11'h1)};
  endfunction
  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one strobed bus cycle; ok low breaks one random select line
  task automatic bus(input logic rd, input logic pick, input logic [7:0] v, input logic ok);
    logic [1:0] k;
    seed = lfsr(seed);
    k = seed[1:0] % 2'd3;
    @(negedge i_clk);
    i_select_high_a = ok || k != 2'd0;
    i_select_high_b = ok || k != 2'd1;
    i_select_low_n  = !ok && k == 2'd2;
    {i_register_pick, i_read_write, i_bus_lines} = {pick, rd, v};
    i_bus_strobe = 1'b1;
    repeat (6) @(negedge i_clk);
    i_bus_strobe = 1'b0;
    repeat (5) @(negedge i_clk);
    i_select_high_a = 1'b0;
  endtask
  task automatic rd(input logic pick, input logic [7:0] x, input logic [7:0] m);
    rq.push_back({m, x & m});
    bus(1'b1, pick, 8'h00, 1'b1);
  endtask
  task automatic wr(input logic pick, input logic [7:0] v);
    bus(1'b0, pick, v, 1'b1);
  endtask
  task automatic wait_got(input int target);
    for (int i = 0; i < 3000 && n_got < target; i++) @(negedge i_clk);
    if (n_got < target) check(11'h1, 11'h0);
  endtask
  // peer sends one frame to the receiver
  task automatic put(input logic [10:0] f, input logic [3:0] c);
    @(negedge i_clk);
    {bits, n, send} = {f, c, 1'b1};
    @(negedge i_clk);
    send = 1'b0;
    for (int i = 0; i < 8000 && busy !== 1'b0; i++) @(negedge i_clk);
    repeat (12) @(negedge i_clk);
  endtask
  // read answer monitor
  always @(negedge i_clk) begin
    if (o_bus_lines_oe === 1'b1 && oe_q !== 1'b1) begin
      if (rq.size() == 0) check(11'h1, 11'h0);
      else begin
        e = rq.pop_front();
        check({3'h0, o_bus_lines & e[15:8]}, {3'h0, e[7:0]});
      end
    end
    oe_q = o_bus_lines_oe;
  end
  // transmitted frame monitor
  always @(posedge got) begin
    n_got++;
    if (tq.size() == 0) check(11'h1, 11'h0);
    else check(frame & ((11'h1 << n) - 11'h1), tq.pop_front());
  end
  initial begin
    #500000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    {i_rst_b, i_select_high_a, i_select_high_b, i_select_low_n} = 4'b0001;
    {i_register_pick, i_read_write, i_bus_strobe, send, oe_q} = 5'h00;
    {i_cts_n, i_dcd_n, i_bus_lines, bits, n} = {2'b00, 8'h00, 11'h000, 4'd9};
    repeat (10) @(negedge i_clk);
    check({7'h0, o_bus_lines_oe, o_irq_oe, o_tx_data, o_rts_n}, 11'h003);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    wr(1'b0, 8'h03);
    wr(1'b0, 8'h14);
    check({10'h0, o_rts_n}, 11'h0);
    bus(1'b0, 1'b0, 8'h54, 1'b0);
    check({10'h0, o_rts_n}, 11'h0);
    wr(1'b0, 8'h54);
    check({10'h0, o_rts_n}, 11'h1);
    wr(1'b0, 8'h14);
    rd(1'b0, 8'h02, 8'hff);
    bus(1'b1, 1'b0, 8'h00, 1'b0);
    // every framing sent once
    for (int w = 0; w < 8; w++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      {n, bits} = frame_of(w[2:0], d);
      tq.push_back(bits);
      wr(1'b0, {3'h0, w[2:0], 2'h0});
      wr(1'b1, d);
      wait_got(w + 1);
      check({10'h0, o_tx_data}, 11'h1);
    end
    // two characters back to back
    wr(1'b0, 8'h14);
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      {n, bits} = frame_of(3'd5, d);
      tq.push_back(bits);
      wr(1'b1, d);
    end
    wait_got(10);
    // clean, bad parity and bad stop receptions
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, rcfg[i]);
      seed = lfsr(seed);
      d = seed[7:0];
      {n, bits} = frame_of(rcfg[i][4:2], d);
      put(bits ^ {2'h0, i != 0, 8'h00}, n);
      rd(1'b0, rexp[i], 8'hff);
      rd(1'b1, d, 8'hff);
      rd(1'b0, 8'h02, 8'h03);
    end
    // overrun by two unread characters
    wr(1'b0, 8'h14);
    {n, bits} = frame_of(3'd5, 8'h5a);
    put(bits, n);
    put(bits, n);
    rd(1'b0, 8'h03, 8'hff);
    rd(1'b1, 8'h5a, 8'hff);
    rd(1'b0, 8'h23, 8'h23);
    rd(1'b1, 8'h00, 8'h00);
    rd(1'b0, 8'h02, 8'h23);
    // oversampled reception at x16 and x64
    for (int i = 0; i < 2; i++) begin
      wr(1'b0, 8'h15 + i[7:0]);
      mul = (i == 0) ? 7'd16 : 7'd64;
      seed = lfsr(seed);
      d = seed[7:0];
      {n, bits} = frame_of(3'd5, d);
      put(bits, n);
      rd(1'b0, 8'h03, 8'hff);
      rd(1'b1, d, 8'hff);
    end
    // short start pulse at x16 must not make a character
    wr(1'b0, 8'h15);
    mul = 7'd4;
    put(11'h000, 4'd0);
    rd(1'b0, 8'h02, 8'hff);
    mul = 7'd1;
    // clear to send withdrawn
    i_cts_n = 1'b1;
    repeat (4) @(negedge i_clk);
    rd(1'b0, 8'h08, 8'hff);
    i_cts_n = 1'b0;
    // carrier lost with receive interrupt enabled
    wr(1'b0, 8'h94);
    i_dcd_n = 1'b1;
    repeat (10) @(negedge i_clk);
    check({10'h0, o_irq_oe}, 11'h1);
    {n, bits} = frame_of(3'd5, 8'h33);
    put(bits, n);
    rd(1'b0, 8'h86, 8'hff);
    rd(1'b1, 8'h00, 8'h00);
    i_dcd_n = 1'b0;
    repeat (10) @(negedge i_clk);
    check({10'h0, o_irq_oe}, 11'h0);
    rd(1'b0, 8'h02, 8'hff);
    print_verdict;
  end
endmodule

// ==== async_serial_adapter_defs.svh ====
`ifndef ASYNC_SERIAL_ADAPTER_DEFS_SVH
`define ASYNC_SERIAL_ADAPTER_DEFS_SVH
// control field positions
`define CFG_DIV_LO       0
`define CFG_DIV_HI       1
`define CFG_WORD_LO      2
`define CFG_WORD_HI      4
`define CFG_TXC_LO       5
`define CFG_TXC_HI       6
`define CFG_RIE          7
// status bit positions
`define ST_RX_FULL       0
`define ST_TX_EMPTY      1
`define ST_CARRIER       2
`define ST_CTS           3
`define ST_FRAME         4
`define ST_OVERRUN       5
`define ST_PARITY        6
`define ST_IRQ           7
// reset values
`define CFG_RESET        8'h03
`define SYNC_RESET       1'b1
// oversample mid points and full counts
`define MID_X16          6'h07
`define MID_X64          6'h1f
`define FULL_X16         6'h0f
`define FULL_X64         6'h3f
`endif

// ==== async_serial_adapter_pkg.sv ====
package async_serial_adapter_pkg;
  typedef enum logic [1:0] {div_1, div_16, div_64, div_reset} divide_t;
  typedef enum logic [1:0] {tx_idle, tx_start, tx_data, tx_stop} tx_state_t;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} rx_state_t;
  // host bus request bundle
  typedef struct packed {
    logic       sel;
    logic       pick;
    logic       read;
    logic [7:0] wdata;
  } bus_req_t;
  // framing decoded from the word field
  typedef struct packed {
    logic eight;
    logic par_en;
    logic par_odd;
    logic two_stop;
  } frame_t;
endpackage

// ==== async_serial_adapter_sva.sv ====
`timescale 1ns/1ps
module async_serial_adapter_sva (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_select_high_a,
  input wire logic i_select_high_b,
  input wire logic i_select_low_n,
  input wire logic i_read_write,
  input wire logic i_bus_strobe,
  input wire logic o_bus_lines_oe,
  input wire logic o_irq_n,
  input wire logic o_irq_oe,
  input wire logic i_tx_bit_clock,
  input wire logic i_rx_bit_clock,
  input wire logic o_tx_data,
  input wire logic i_cts_n,
  input wire logic i_dcd_n,
  input wire logic o_rts_n
);
  logic [3:0] rd_q, rd_d, tx_q, tx_d, wr_q, wr_d, ev_q, ev_d;
  logic [4:0] pin_q, pin_d;
  logic       sel;
  assign sel = i_select_high_a && i_select_high_b && !i_select_low_n;
  function automatic logic [3:0] sat(input logic [3:0] v);
    return v + {3'h0, v != 4'hf};
  endfunction
  // cycles since read strobe, tx clock fall, write end and irq cause
  always_comb begin
    pin_d = {i_tx_bit_clock, i_rx_bit_clock, i_dcd_n, i_cts_n, i_bus_strobe};
    rd_d  = (sel && i_read_write && i_bus_strobe) ? 4'h0 : sat(rd_q);
    tx_d  = (pin_q[4] && !i_tx_bit_clock) ? 4'h0 : sat(tx_q);
    wr_d  = (pin_q[0] && !i_bus_strobe && sel && !i_read_write) ? 4'h0 : sat(wr_q);
    ev_d  = ((pin_q[0] & ~i_bus_strobe) | (~pin_q[3] & i_rx_bit_clock) |
             (pin_q[4] & ~i_tx_bit_clock) | (~pin_q[2] & i_dcd_n) |
             (pin_q[1] & ~i_cts_n)) ? 4'h0 : sat(ev_q);
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      {rd_q, tx_q, wr_q, ev_q} <= 16'hf000;
      pin_q <= 5'h00;
    end else begin
      {rd_q, tx_q, wr_q, ev_q} <= {rd_d, tx_d, wr_d, ev_d};
      pin_q <= pin_d;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_OE_NEEDS_READ: assert property (o_bus_lines_oe |-> rd_q <= 4'h5)
    else $error("bus driven without a selected read");
  AST_READ_ANSWER: assert property (
    sel && i_read_write && $rose(i_bus_strobe) |-> ##[3:5] o_bus_lines_oe)
    else $error("selected read not answered");
  AST_OE_RELEASE: assert property ($fell(i_bus_strobe) |-> ##[2:6] !o_bus_lines_oe)
    else $error("bus drivers not released");
  AST_OE_HOLD: assert property (
    o_bus_lines_oe && sel && i_read_write && i_bus_strobe |=> o_bus_lines_oe)
    else $error("read data dropped during strobe");
  AST_IRQ_LEVEL: assert property (!o_irq_n)
    else $error("interrupt pin value not low");
  AST_IRQ_CAUSE: assert property ($rose(o_irq_oe) |-> ev_q <= 4'h8)
    else $error("interrupt without a cause");
  AST_TX_ON_FALL: assert property ($changed(o_tx_data) |-> tx_q <= 4'h6)
    else $error("serial bit not launched on clock fall");
  AST_RTS_ON_WRITE: assert property ($changed(o_rts_n) |-> wr_q <= 4'h7)
    else $error("request to send changed without a write");
  cover property ($rose(o_bus_lines_oe));
  cover property ($rose(o_irq_oe));
  cover property ($fell(o_tx_data));
endmodule

bind async_serial_adapter async_serial_adapter_sva u_sva (.*);

// ==== async_serial_bit_timer.sv ====
`timescale 1ns/1ps
`include "async_serial_adapter_defs.svh"
// turns bit clock edges into bit ticks per divide ratio
module async_serial_bit_timer
  import async_serial_adapter_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst_b,
  input  wire logic   i_edge,
  input  wire logic   i_restart,
  input  wire logic   i_half,
  input  wire divide_t i_div,
  output logic        o_tick
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [5:0] lim;

  // count edges to the full or middle point
  always_comb begin
    lim = (i_div == div_64) ? (i_half ? `MID_X64 : `FULL_X64)
                            : (i_half ? `MID_X16 : `FULL_X16);
    cnt_d  = cnt_q;
    o_tick = 1'b0;
    if (i_restart) begin
      cnt_d = 6'h00;
    end else if (i_edge) begin
      if (i_div == div_1 || cnt_q == lim) begin
        o_tick = 1'b1;
        cnt_d  = 6'h00;
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ==== async_serial_peer.sv ====
`timescale 1ns/1ps
module async_serial_peer (
  input  wire logic        i_send,
  input  wire logic [10:0] i_bits,
  input  wire logic [3:0]  i_n,
  input  wire logic [6:0]  i_mul,
  input  wire logic        i_line,
  output logic             o_bit_clock,
  output logic             o_rx_line,
  output logic             o_busy,
  output logic             o_got,
  output logic [10:0]      o_frame
);
  int cnt = 0;
  // free running modem bit clock
  initial begin
    o_bit_clock = 1'b1;
    forever #80 o_bit_clock = ~o_bit_clock;
  end
  // frame sender, bits change on the fall so the rise sees them settled
  initial begin
    o_rx_line = 1'b1;
    o_busy = 1'b0;
    forever begin
      @(posedge i_send);
      o_busy = 1'b1;
      @(negedge o_bit_clock) o_rx_line = 1'b0;
      // each level held for i_mul bit clock periods
      for (int k = 0; k < i_n; k++) begin
        repeat (i_mul) @(negedge o_bit_clock);
        o_rx_line = i_bits[k];
      end
      repeat (i_mul) @(negedge o_bit_clock);
      o_rx_line = 1'b1;
      o_busy = 1'b0;
    end
  end
  // frame catcher, reads each bit at the fall after its launch
  always @(negedge o_bit_clock) begin
    o_got <= 1'b0;
    if (cnt == 0) begin
      if (i_line === 1'b0) cnt <= 1;
    end else begin
      o_frame[cnt-1] <= i_line;
      o_got <= (cnt == i_n);
      cnt <= (cnt == i_n) ? 0 : cnt + 1;
    end
  end
endmodule
